/* File: rtl/gls_gpio_port.sv */
// gpio port with per-pin level watch, sticky hit flags and axi4-lite registers
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module gls_gpio_port #(
  parameter int unsigned PINS = 32
) (
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             s_axi_awvalid_in,
  output logic                  s_axi_awready_out,
  input  wire logic [11:0]      s_axi_awaddr_in,
  input  wire logic [2:0]       s_axi_awprot_in,
  input  wire logic             s_axi_wvalid_in,
  output logic                  s_axi_wready_out,
  input  wire logic [31:0]      s_axi_wdata_in,
  input  wire logic [3:0]       s_axi_wstrb_in,
  output logic                  s_axi_bvalid_out,
  input  wire logic             s_axi_bready_in,
  output logic [1:0]            s_axi_bresp_out,
  input  wire logic             s_axi_arvalid_in,
  output logic                  s_axi_arready_out,
  input  wire logic [11:0]      s_axi_araddr_in,
  input  wire logic [2:0]       s_axi_arprot_in,
  output logic                  s_axi_rvalid_out,
  input  wire logic             s_axi_rready_in,
  output logic [31:0]           s_axi_rdata_out,
  output logic [1:0]            s_axi_rresp_out,
  input  wire logic [PINS-1:0]  pad_in_in,
  output logic [PINS-1:0]       pad_out_out,
  output logic [PINS-1:0]       pad_oe_out,
  output logic [PINS-1:0]       pad_pull_up_out,
  output logic [PINS-1:0]       pad_pull_down_out,
  output logic [3*PINS-1:0]     pad_drive_out,
  output logic [PINS-1:0]       pad_input_enable_out,
  output logic [PINS-1:0]       analog_pin_input_out,
  input  wire logic [PINS-1:0]  secure_pins_in,
  input  wire logic [PINS-1:0]  periph_own_in,
  input  wire logic [PINS-1:0]  periph_out_in,
  input  wire logic [PINS-1:0]  periph_oe_in,
  output logic [PINS-1:0]       periph_in_out,
  output logic                  nonsecure_port_hit_out,
  output logic                  secure_port_hit_out,
  output logic                  sticky_hit_signal_out,
  output logic                  wake_out
);

  typedef struct packed {
    logic [PINS-1:0]        out_value;
    logic [PINS-1:0][31:0]  setup;
    logic [PINS-1:0]        flags;
    logic                   sel_ns;
    logic                   sel_sec;
    logic [PINS-1:0]        sync1;
    logic [PINS-1:0]        sync2;
    logic [PINS-1:0]        hit_prev;
    logic                   rearm;
    logic                   aw_hold;
    logic [11:0]            awaddr;
    logic                   aw_ns;
    logic                   w_hold;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } gls_state_type;

  gls_state_type st;
  gls_state_type next_st;

  logic [PINS-1:0] connected;
  logic [PINS-1:0] dir_now;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] clr;
  logic [PINS-1:0] wr_ok;
  logic [PINS-1:0] rd_ok;
  logic [PINS-1:0] in_value;
  logic [31:0]     bm;
  logic [11:0]     wofs;
  logic [11:0]     rofs;
  logic            do_write;
  logic            ar_take;
  logic            sticky_ns;
  logic            sticky_sec;
  logic            comb_ns;
  logic            comb_sec;

  // per-pin field decode and pad drive
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    logic [1:0] watch;
    logic [1:0] pull;
    assign watch = st.setup[g][gls_pkg::WATCH_LSB +: 2];
    assign pull  = st.setup[g][gls_pkg::PULL_LSB +: 2];
    assign dir_now[g]   = st.setup[g][gls_pkg::DIR_BIT];
    assign connected[g] = ~st.setup[g][gls_pkg::DISC_BIT];
    // combinational compare, no clock gating, so hits reach wake in sleep
    assign hit[g] = connected[g] &
                    (((watch == gls_pkg::WATCH_HIGH) & st.sync2[g]) |
                     ((watch == gls_pkg::WATCH_LOW) & ~st.sync2[g]));
    assign pad_out_out[g] = periph_own_in[g] ? periph_out_in[g] : st.out_value[g];
    assign pad_oe_out[g]  = periph_own_in[g] ? periph_oe_in[g] : dir_now[g];
    assign pad_pull_up_out[g]   = (pull == gls_pkg::PULL_UP);
    assign pad_pull_down_out[g] = (pull == gls_pkg::PULL_DOWN);
    assign pad_drive_out[3*g +: 3] = st.setup[g][gls_pkg::DRIVE_LSB +: 3];
    assign pad_input_enable_out[g] = connected[g];
    assign analog_pin_input_out[g] = st.setup[g][gls_pkg::ANALOG_BIT];
  end

  assign in_value      = st.sync2 & connected;
  assign periph_in_out = in_value;
  assign rise          = hit & ~st.hit_prev;

  // sticky-hit drops for one cycle after any flag clear write
  assign sticky_ns  = |(st.flags & ~secure_pins_in) & ~st.rearm;
  assign sticky_sec = |(st.flags & secure_pins_in) & ~st.rearm;
  assign comb_ns    = |(hit & ~secure_pins_in);
  assign comb_sec   = |(hit & secure_pins_in);
  assign nonsecure_port_hit_out = st.sel_ns ? sticky_ns : comb_ns;
  assign secure_port_hit_out    = st.sel_sec ? sticky_sec : comb_sec;
  assign sticky_hit_signal_out  = sticky_ns;
  assign wake_out = nonsecure_port_hit_out | secure_port_hit_out;

  assign s_axi_awready_out = ~st.aw_hold;
  assign s_axi_wready_out  = ~st.w_hold;
  assign s_axi_bvalid_out  = st.bvalid;
  assign s_axi_bresp_out   = st.bresp;
  assign s_axi_arready_out = ~st.rvalid;
  assign s_axi_rvalid_out  = st.rvalid;
  assign s_axi_rdata_out   = st.rdata;
  assign s_axi_rresp_out   = st.rresp;

  assign do_write = st.aw_hold & st.w_hold & ~st.bvalid;
  assign ar_take  = s_axi_arvalid_in & ~st.rvalid;
  assign wofs     = {st.awaddr[11:2], 2'b00};
  assign rofs     = {s_axi_araddr_in[11:2], 2'b00};
  assign bm       = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
  assign wr_ok    = st.aw_ns ? ~secure_pins_in : '1;
  assign rd_ok    = s_axi_arprot_in[1] ? ~secure_pins_in : '1;
  assign clr = (do_write && wofs == gls_pkg::OFS_FLAGS) ?
               (st.wdata[PINS-1:0] & bm[PINS-1:0] & wr_ok) : '0;

  always_comb begin
    logic [PINS-1:0] wm;
    logic [PINS-1:0] wd;
    logic [PINS-1:0] dnew;
    logic            dir_wr;
    logic            hit_reg;
    logic [31:0]     rd;
    logic            rd_hit;
    wm      = bm[PINS-1:0] & wr_ok;
    wd      = st.wdata[PINS-1:0];
    dnew    = dir_now;
    dir_wr  = 1'b0;
    hit_reg = 1'b1;
    rd      = 32'h0000_0000;
    rd_hit  = 1'b1;
    next_st = st;
    next_st.sync1    = pad_in_in;
    next_st.sync2    = st.sync1;
    next_st.hit_prev = hit;
    next_st.rearm    = |clr | (do_write && wofs == gls_pkg::OFS_FLAGS);
    // set wins over clear; a high hit blocks its own clear; falling hit ignored
    next_st.flags = (st.flags & ~(clr & ~hit)) | rise;
    if (s_axi_awvalid_in && !st.aw_hold) begin
      next_st.aw_hold = 1'b1;
      next_st.awaddr  = s_axi_awaddr_in;
      next_st.aw_ns   = s_axi_awprot_in[1];
    end
    if (s_axi_wvalid_in && !st.w_hold) begin
      next_st.w_hold = 1'b1;
      next_st.wdata  = s_axi_wdata_in;
      next_st.wstrb  = s_axi_wstrb_in;
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (do_write) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold  = 1'b0;
      next_st.bvalid  = 1'b1;
      case (wofs)
        gls_pkg::OFS_OUT:     next_st.out_value = (st.out_value & ~wm) | (wd & wm);
        gls_pkg::OFS_OUTSET:  next_st.out_value = st.out_value | (wd & wm);
        gls_pkg::OFS_OUTCLR:  next_st.out_value = st.out_value & ~(wd & wm);
        gls_pkg::OFS_IN:      hit_reg = 1'b1;
        gls_pkg::OFS_DIR: begin
          dnew   = (dir_now & ~wm) | (wd & wm);
          dir_wr = 1'b1;
        end
        gls_pkg::OFS_DIRSET: begin
          dnew   = dir_now | (wd & wm);
          dir_wr = 1'b1;
        end
        gls_pkg::OFS_DIRCLR: begin
          dnew   = dir_now & ~(wd & wm);
          dir_wr = 1'b1;
        end
        gls_pkg::OFS_FLAGS:   hit_reg = 1'b1;
        gls_pkg::OFS_SEL_NS: begin
          if (st.wstrb[0]) begin
            next_st.sel_ns = st.wdata[0];
          end
        end
        gls_pkg::OFS_SEL_SEC: begin
          if (st.wstrb[0] && !st.aw_ns) begin
            next_st.sel_sec = st.wdata[0];
          end
        end
        default: begin
          hit_reg = 1'b0;
          for (int i = 0; i < PINS; i++) begin
            if (wofs == gls_pkg::OFS_SETUP + 12'(4 * i)) begin
              hit_reg = 1'b1;
              if (wr_ok[i]) begin
                next_st.setup[i] = ((st.setup[i] & ~bm) | (st.wdata & bm)) &
                                   gls_pkg::SETUP_MASK;
              end
            end
          end
        end
      endcase
      if (dir_wr) begin
        for (int i = 0; i < PINS; i++) begin
          next_st.setup[i][gls_pkg::DIR_BIT] = dnew[i];
        end
      end
      next_st.bresp = hit_reg ? gls_pkg::RESP_OKAY : gls_pkg::RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      case (rofs)
        gls_pkg::OFS_OUT,
        gls_pkg::OFS_OUTSET,
        gls_pkg::OFS_OUTCLR:  rd = 32'(st.out_value & rd_ok);
        gls_pkg::OFS_IN:      rd = 32'(in_value & rd_ok);
        gls_pkg::OFS_DIR,
        gls_pkg::OFS_DIRSET,
        gls_pkg::OFS_DIRCLR:  rd = 32'(dir_now & rd_ok);
        gls_pkg::OFS_FLAGS:   rd = 32'(st.flags & rd_ok);
        gls_pkg::OFS_SEL_NS:  rd = 32'(st.sel_ns);
        gls_pkg::OFS_SEL_SEC: rd = s_axi_arprot_in[1] ? 32'h0000_0000 : 32'(st.sel_sec);
        default: begin
          rd_hit = 1'b0;
          for (int i = 0; i < PINS; i++) begin
            if (rofs == gls_pkg::OFS_SETUP + 12'(4 * i)) begin
              rd_hit = 1'b1;
              rd     = rd_ok[i] ? st.setup[i] : 32'h0000_0000;
            end
          end
        end
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = rd_hit ? gls_pkg::RESP_OKAY : gls_pkg::RESP_SLVERR;
    end
  end

  // setup words sit in the retained domain; only the port reset loads them with SETUP_RESET (input disconnected)
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st           <= '0;
      st.out_value <= gls_pkg::OUT_RESET[PINS-1:0];
      st.setup     <= {PINS{gls_pkg::SETUP_RESET}};
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_in_delay;
    $past(nrst_in, 2) |-> st.sync2 == $past(pad_in_in, 2);
  endproperty
  a_in_delay: assert property (p_in_delay) else $error("input delay not 2 cycles");

  property p_rise_sets;
    (|rise) |=> ((st.flags & $past(rise)) == $past(rise));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising hit did not set flag");

  property p_hold_while_hit;
    1'b1 |=> ((~st.flags & $past(st.flags & hit)) == '0);
  endproperty
  a_hold_while_hit: assert property (p_hold_while_hit) else $error("flag cleared under hit");

  property p_drop_needs_clear;
    1'b1 |=> (($past(st.flags) & ~st.flags & ~$past(clr)) == '0);
  endproperty
  a_drop_needs_clear: assert property (p_drop_needs_clear) else $error("flag lost");

  property p_empty_low;
    (st.flags == '0) |-> !sticky_ns && !sticky_sec;
  endproperty
  a_empty_low: assert property (p_empty_low) else $error("sticky high with no flag");

  property p_fresh_edge;
    (do_write && wofs == gls_pkg::OFS_FLAGS) |=>
      !sticky_ns ##1 (sticky_ns == |(st.flags & ~secure_pins_in));
  endproperty
  a_fresh_edge: assert property (p_fresh_edge) else $error("no fresh sticky edge");

  property p_comb_mode;
    (!st.sel_ns && comb_ns) |-> nonsecure_port_hit_out && wake_out;
  endproperty
  a_comb_mode: assert property (p_comb_mode) else $error("port hit missing");

  property p_secure_out_kept;
    (do_write && st.aw_ns) |=>
      (((st.out_value ^ $past(st.out_value)) & $past(secure_pins_in)) == '0);
  endproperty
  a_secure_out_kept: assert property (p_secure_out_kept) else $error("ns wrote secure pin");

  property p_disc_no_hit;
    (hit & ~connected) == '0 && (in_value & ~connected) == '0;
  endproperty
  a_disc_no_hit: assert property (p_disc_no_hit) else $error("disconnected pin seen");

  property p_bvalid_hold;
    (st.bvalid && !s_axi_bready_in) |=> st.bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");

  property p_rvalid_hold;
    (st.rvalid && !s_axi_rready_in) |=> st.rvalid && $stable(st.rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data not held");

  property p_sel_sec_kept;
    (do_write && st.aw_ns) |=> $stable(st.sel_sec);
  endproperty
  a_sel_sec_kept: assert property (p_sel_sec_kept) else $error("ns wrote secure select");

  property p_clear_works;
    (|clr) |=> ((st.flags & $past(clr & ~hit)) == '0);
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("flag clear lost");

  property p_cov_refire;
    (do_write && wofs == gls_pkg::OFS_FLAGS) ##1 !sticky_ns ##1 sticky_ns;
  endproperty
  c_cov_refire: cover property (p_cov_refire);

  property p_cov_sticky_mode;
    st.sel_ns && nonsecure_port_hit_out;
  endproperty
  c_cov_sticky_mode: cover property (p_cov_sticky_mode);

  property p_cov_secure_hit;
    secure_port_hit_out && !nonsecure_port_hit_out;
  endproperty
  c_cov_secure_hit: cover property (p_cov_secure_hit);

  property p_cov_blocked_clear;
    |(clr & hit);
  endproperty
  c_cov_blocked_clear: cover property (p_cov_blocked_clear);

  property p_cov_override;
    |periph_own_in;
  endproperty
  c_cov_override: cover property (p_cov_override);

endmodule : gls_gpio_port
`default_nettype wire

/* File: rtl/gls_pkg.sv */
// constants for the level-sense gpio port
// Summary of operation
// - port has up to 32 pins, each set up by its own pin setup word
// - setup word holds direction, drive, pulls, level watch, input disconnect, analog select
// - pin setup words are retained and set to SETUP_RESET (input disconnected) only by the port reset
// - level-watch field selects watching for high or for low input level
// - each pin drives its own level-hit while input equals the watched level
// - default mode ORs non-secure pin level-hits into one port-wide hit and secure pin level-hits into another
// - level-hit and port-wide hit paths work in running and deep-sleep states
// - secure hit-source select governs secure pins, ordinary select non-secure pins
// - enabling watch on a matching pin raises level-hit at once
// - port-wide hit wakes the system and feeds the any-pin event
// - rising level-hit of pin n sets sticky flag bit n
// - sticky bit clears only on written one, and not while level-hit high
// - falling level-hit leaves sticky flags untouched
// - sticky-hit signal is high while any sticky flag bit of a non-secure pin is one
// - clear write leaving flags set gives a fresh sticky-hit rising edge
// - sticky flag register readable at any time, whatever source selected
// - hit-source select switches port-wide hit from combined hits to sticky-hit
// - disconnected input shows no valid level and is not watched
// - peripherals may override pin output value and output enable and read its input
// - pad change reaches the input value register after 2 clock cycles
// - non-secure access to secure pin bits: writes ignored, reads zero
// - non-secure hit goes to ordinary, secure hit to secure task/event block
package gls_pkg;
  localparam logic [11:0] OFS_OUT     = 12'h004;
  localparam logic [11:0] OFS_OUTSET  = 12'h008;
  localparam logic [11:0] OFS_OUTCLR  = 12'h00c;
  localparam logic [11:0] OFS_IN      = 12'h010;
  localparam logic [11:0] OFS_DIR     = 12'h014;
  localparam logic [11:0] OFS_DIRSET  = 12'h018;
  localparam logic [11:0] OFS_DIRCLR  = 12'h01c;
  localparam logic [11:0] OFS_FLAGS   = 12'h020;
  localparam logic [11:0] OFS_SEL_NS  = 12'h024;
  localparam logic [11:0] OFS_SEL_SEC = 12'h028;
  localparam logic [11:0] OFS_SETUP   = 12'h200;
  localparam int DIR_BIT    = 0;
  localparam int DISC_BIT   = 1;
  localparam int PULL_LSB   = 2;
  localparam int DRIVE_LSB  = 8;
  localparam int WATCH_LSB  = 16;
  localparam int ANALOG_BIT = 20;
  localparam logic [1:0] PULL_DOWN  = 2'h1;
  localparam logic [1:0] PULL_UP    = 2'h3;
  localparam logic [1:0] WATCH_OFF  = 2'h0;
  localparam logic [1:0] WATCH_HIGH = 2'h2;
  localparam logic [1:0] WATCH_LOW  = 2'h3;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0002;
  localparam logic [31:0] SETUP_MASK  = 32'h0013_070f;
  localparam logic [31:0] OUT_RESET   = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gls_pkg

/* File: sim/gls_pad_model.sv */
// far-side model of the pads: outside driver or the port itself
`timescale 1ns/1ns
`default_nettype none
module gls_pad_model #(
  parameter int unsigned PINS = 32
) (
  input  wire logic [PINS-1:0] ext_level_in,
  input  wire logic [PINS-1:0] dev_out_in,
  input  wire logic [PINS-1:0] dev_oe_in,
  output logic      [PINS-1:0] pad_level_out
);
  // port drive wins where enabled, else the outside driver holds the pad
  assign pad_level_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & ext_level_in);
endmodule : gls_pad_model
`default_nettype wire

/* File: sim/gls_gpio_port_test.sv */
// self-checking bench for the level-sense gpio port
`timescale 1ns/1ns
`default_nettype none
module gls_gpio_port_test;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [11:0]      awa = 12'h000, ara = 12'h000;
  logic [2:0]       prot = 3'h0;
  logic [31:0]      wd = 32'h0, ext = 32'h0, sec = 32'h0, own = 32'h0, pout = 32'h0;
  logic [31:0]      poe = 32'h0, got, d, m;
  logic [1:0]       resp;
  logic             st_prev = 1'b0;
  wire logic        awr, wrdy, bv, arr, rv, nhit, shit, sticky, wake;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, pad, dout, doe, pin, pu, pd, ie, an;
  wire logic [95:0] drv;
  int               n_mismatch = 0;
  int               tests_run = 0;
  int               rises = 0;
  int               p, q, r, s, i;

  always #25 clk = ~clk;

  gls_pad_model pad_u (.ext_level_in(ext), .dev_out_in(dout), .dev_oe_in(doe),
    .pad_level_out(pad));
  gls_gpio_port dut_u (.ref_clk_in(clk), .nrst_in(nrst), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_awprot_in(prot),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_arprot_in(prot), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rre), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .pad_in_in(pad), .pad_out_out(dout), .pad_oe_out(doe), .pad_pull_up_out(pu),
    .pad_pull_down_out(pd), .pad_drive_out(drv), .pad_input_enable_out(ie),
    .analog_pin_input_out(an), .secure_pins_in(sec), .periph_own_in(own),
    .periph_out_in(pout), .periph_oe_in(poe), .periph_in_out(pin),
    .nonsecure_port_hit_out(nhit), .secure_port_hit_out(shit),
    .sticky_hit_signal_out(sticky), .wake_out(wake));

  // rising edges of the sticky-hit signal
  always @(negedge clk) begin
    if (sticky === 1'b1 && st_prev !== 1'b1)
      rises++;
    st_prev = sticky;
  end

  function automatic logic [11:0] su(input int n);
    return gls_pkg::OFS_SETUP + 12'(4 * n);
  endfunction : su

  function automatic logic [31:0] watch_w(input logic [1:0] w);
    return 32'(w) << gls_pkg::WATCH_LSB;
  endfunction : watch_w

  function automatic logic [31:0] ovr(input logic [31:0] v, input logic [31:0] o,
                                      input logic [31:0] pv);
    return (v & ~o) | (pv & o);
  endfunction : ovr

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, g, e);
    end
  endtask : chk

  // ends at a falling edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  task automatic pad_set(input int idx, input logic v);
    @(posedge clk);
    ext[idx] <= v;
  endtask : pad_set

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic ns);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= v;
    prot <= {1'b0, ns, 1'b0};
    bre <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv && bre;
      resp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bre <= 1'b0;
    chk({30'h0, resp}, {30'h0, gls_pkg::RESP_OKAY}, "write resp");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic ns);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    prot <= {1'b0, ns, 1'b0};
    rre <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv && rre;
      got = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rre <= 1'b0;
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic ns, input logic [31:0] e);
    rd(a, ns);
    chk(got, e, "read data");
    chk({30'h0, resp}, {30'h0, gls_pkg::RESP_OKAY}, "read resp");
  endtask : rc

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    got = $urandom(32812);
    p = $urandom_range(15, 1);
    q = p - 1;
    r = p + 1;
    s = $urandom_range(31, 17);
    m = (32'h1 << p) | (32'h1 << q) | (32'h1 << r);
    sec <= 32'h1 << s;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rc(su(p), 1'b1, gls_pkg::SETUP_RESET);
    rd(12'h000, 1'b1);
    chk({30'h0, resp}, {30'h0, gls_pkg::RESP_SLVERR}, "unmapped resp");
    chk(got, 32'h0, "unmapped data");
    @(posedge clk);
    ext <= ($urandom() & ~(32'h1 << p)) | (32'h1 << q);
    wr(su(p), watch_w(gls_pkg::WATCH_HIGH), 1'b1);
    wr(su(q), watch_w(gls_pkg::WATCH_LOW), 1'b1);
    wr(su(r), 32'h0, 1'b1);
    rc(su(p), 1'b1, watch_w(gls_pkg::WATCH_HIGH));
    rc(gls_pkg::OFS_IN, 1'b1, ext & m);
    cyc(1);
    chk({31'h0, nhit}, 32'h0, "parked hit");
    d = ext;
    pad_set(r, ~ext[r]);
    @(negedge clk);
    @(negedge clk);
    chk(pin, d & m, "input early");
    @(negedge clk);
    chk(pin, (d ^ (32'h1 << r)) & m, "input late");
    pad_set(p, 1'b1);
    cyc(4);
    chk({30'h0, nhit, wake}, 32'h3, "level hit");
    rc(gls_pkg::OFS_FLAGS, 1'b1, 32'h1 << p);
    wr(gls_pkg::OFS_FLAGS, 32'h1 << p, 1'b1);
    rc(gls_pkg::OFS_FLAGS, 1'b1, 32'h1 << p);
    pad_set(p, 1'b0);
    cyc(4);
    chk({30'h0, nhit, sticky}, 32'h1, "hit gone");
    rc(gls_pkg::OFS_FLAGS, 1'b1, 32'h1 << p);
    pad_set(q, 1'b0);
    cyc(4);
    chk({31'h0, nhit}, 32'h1, "low watch");
    pad_set(q, 1'b1);
    cyc(4);
    i = rises;
    wr(gls_pkg::OFS_FLAGS, 32'h1 << p, 1'b1);
    cyc(2);
    chk(32'(rises - i), 32'h1, "fresh edge");
    pad_set(s, 1'b1);
    wr(su(s), watch_w(gls_pkg::WATCH_HIGH), 1'b0);
    cyc(1);
    chk({29'h0, shit, nhit, wake}, 32'h5, "secure hit");
    rc(gls_pkg::OFS_FLAGS, 1'b1, 32'h1 << q);
    wr(su(s), 32'h0, 1'b1);
    rc(su(s), 1'b1, 32'h0);
    rc(su(s), 1'b0, watch_w(gls_pkg::WATCH_HIGH));
    wr(gls_pkg::OFS_SEL_SEC, 32'h1, 1'b1);
    rc(gls_pkg::OFS_SEL_SEC, 1'b0, 32'h0);
    wr(gls_pkg::OFS_FLAGS, 32'hffff_ffff, 1'b1);
    wr(gls_pkg::OFS_SEL_NS, 32'h1, 1'b1);
    rc(gls_pkg::OFS_SEL_NS, 1'b1, 32'h1);
    pad_set(p, 1'b1);
    cyc(4);
    pad_set(p, 1'b0);
    cyc(4);
    chk({30'h0, nhit, sticky}, 32'h3, "sticky source");
    wr(gls_pkg::OFS_FLAGS, 32'h1 << p, 1'b1);
    cyc(2);
    chk({30'h0, nhit, sticky}, 32'h0, "sticky cleared");
    wr(gls_pkg::OFS_SEL_NS, 32'h0, 1'b1);
    wr(su(p), watch_w(gls_pkg::WATCH_OFF), 1'b1);
    pad_set(p, 1'b1);
    cyc(4);
    chk({31'h0, nhit}, 32'h0, "watch off");
    wr(su(p), watch_w(gls_pkg::WATCH_HIGH) | 32'h2, 1'b1);
    cyc(2);
    chk({31'h0, nhit}, 32'h0, "disconnected");
    rc(gls_pkg::OFS_FLAGS, 1'b1, 32'h0);
    d = (32'($urandom_range(7, 0)) << gls_pkg::DRIVE_LSB) |
        (32'(gls_pkg::PULL_UP) << gls_pkg::PULL_LSB) |
        (32'h1 << gls_pkg::ANALOG_BIT) | (32'h1 << gls_pkg::DISC_BIT);
    wr(su(r), d, 1'b1);
    wr(su(q), 32'(gls_pkg::PULL_DOWN) << gls_pkg::PULL_LSB, 1'b1);
    cyc(1);
    chk({27'h0, pu[r], pd[q], an[r], ie[r], ie[q]}, 32'h1d, "pad setup");
    chk({29'h0, drv[3*r +: 3]}, (d >> gls_pkg::DRIVE_LSB) & 32'h7, "pad drive");
    for (i = 0; i < 4; i++) begin
      d = $urandom();
      m = $urandom();
      @(posedge clk);
      own <= $urandom();
      pout <= $urandom();
      poe <= $urandom();
      wr(gls_pkg::OFS_OUT, d, 1'b0);
      wr(gls_pkg::OFS_DIR, m, 1'b0);
      cyc(1);
      chk(dout, ovr(d, own, pout), "pad out");
      chk(doe, ovr(m, own, poe), "pad enable");
    end
    final_report();
  end
endmodule : gls_gpio_port_test
`default_nettype wire
